// *** verilog/scp_pkg.sv ***
`default_nettype none
package scp_pkg;
  // Core clock.
  localparam int CLK_PERIOD_NS = 4;
  // Bus silence after power-up, 5.5 ms, rounded up to whole cycles.
  localparam int PWRUP_TIME_US = 5500;
  localparam int PWRUP_CYC     = (PWRUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock-low timeout, 30 ms.
  localparam int TIMEOUT_TIME_MS = 30;
  localparam int TIMEOUT_CYC     = (TIMEOUT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // Idle reset, 200 us with both lines high.
  localparam int IDLE_TIME_US = 200;
  localparam int IDLE_CYC     = (IDLE_TIME_US * 1000) / CLK_PERIOD_NS;
  // Host wait after a waking read, 3 ms, rounded up.
  localparam int WAKE_TIME_MS = 3;
  localparam int WAKE_CYC     = (WAKE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host bus clock quarter period in core cycles.
  localparam logic [7:0] HOST_QTR_CYC = 8'h0A;

  // Client register map.
  localparam logic [7:0] REG_CTRL           = 8'h00;
  localparam logic [7:0] REG_STRAP          = 8'h01;
  localparam logic [7:0] REG_PRODUCT_IDENTIFIER     = 8'hFD;
  localparam logic [7:0] REG_MAKER_ID       = 8'hFE;
  localparam logic [7:0] REG_PART_REVISION  = 8'hFF;
  // Identification values are arbitrary.
  localparam logic [7:0] PRODUCT_IDENTIFIER_VAL     = 8'h3C;
  localparam logic [7:0] MAKER_ID_VAL       = 8'hA5;
  localparam logic [7:0] PART_REVISION_VAL  = 8'h11;
  localparam int         CTRL_TDIS_BIT      = 0;
  localparam int         CTRL_SLEEP_BIT     = 1;
  localparam logic [7:0] CTRL_MASK          = 8'h03;
  localparam logic [7:0] CTRL_RESET         = 8'h01;

  // Address per strap step 0..7; steps 8..15 mirror them.
  localparam logic [7:0][6:0] ADDR_TABLE = {7'h33, 7'h32, 7'h31, 7'h30,
                                            7'h54, 7'h55, 7'h56, 7'h57};

  // Host register map on APB.
  localparam logic [7:0] HREG_CMD    = 8'h00;
  localparam logic [7:0] HREG_TARGET = 8'h04;
  localparam logic [7:0] HREG_REGPTR = 8'h08;
  localparam logic [7:0] HREG_WDATA  = 8'h0C;
  localparam logic [7:0] HREG_RDATA  = 8'h10;
  localparam logic [7:0] HREG_STATUS = 8'h14;
  localparam logic [1:0] OP_WRITE    = 2'h0;
  localparam logic [1:0] OP_SEND     = 2'h1;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_RECEIVE  = 2'h3;
  localparam int         CMD_WAKE_BIT = 2;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_HACK} scp_dev_state_t;
  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} scp_byte_kind_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} scp_host_state_t;
endpackage : scp_pkg
`default_nettype wire

// *** verilog/scp_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface scp_link_if;
  logic scl_oe;
  logic scl_out;
  logic sda_h_oe;
  logic sda_h_out;
  logic sda_d_oe;
  logic sda_d_out;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups.
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((sda_h_oe & ~sda_h_out) | (sda_d_oe & ~sda_d_out));

  modport device (input scl, input sda, output sda_d_oe, output sda_d_out);
  modport host (input sda, output scl_oe, output scl_out, output sda_h_oe, output sda_h_out);
endinterface : scp_link_if
`default_nettype wire

// *** verilog/scp_client_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
module scp_client_dev #(
  parameter int PWRUP_CYCLES   = scp_pkg::PWRUP_CYC,
  parameter int TIMEOUT_CYCLES = scp_pkg::TIMEOUT_CYC,
  parameter int IDLE_CYCLES    = scp_pkg::IDLE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  scp_link_if.device      link,
  input  wire logic [3:0] mode_limit_strap_pin,
  input  wire logic [3:0] addr_strap_pin,
  input  wire logic       port_power_enable,
  output logic            bus_ready,
  output logic            smbus_mode,
  output logic [2:0]      hardware_current_limit,
  output logic [6:0]      client_address,
  output logic            enable_active_high,
  output logic            port_switch_on,
  output logic            timeout_disable_bit,
  output logic            asleep
);
  import scp_pkg::*;

  logic [10:0]    sy1_q;
  logic [10:0]    sy2_q;
  logic           scl_p_q;
  logic           sda_p_q;
  logic [23:0]    pwr_cnt_q;
  logic           ready_q;
  logic [3:0]     mode_strap_q;
  logic [3:0]     addr_strap_q;
  logic           sw_on_q;
  logic           mode_bus_q;
  logic [6:0]     addr_q;
  logic [23:0]    low_cnt_q;
  logic [23:0]    hi_cnt_q;
  scp_dev_state_t st_q;
  scp_byte_kind_t kind_q;
  logic [3:0]     cnt_q;
  logic [7:0]     sh_q;
  logic [7:0]     tx_q;
  logic           rw_q;
  logic [7:0]     ptr_q;
  logic           sda_oe_q;
  logic [7:0]     ctrl_q;

  wire       scl_s      = sy2_q[0];
  wire       sda_s      = sy2_q[1];
  wire [3:0] mode_s     = sy2_q[5:2];
  wire [3:0] addr_s     = sy2_q[9:6];
  wire       pen_s      = sy2_q[10];
  wire       scl_rise   = scl_s & ~scl_p_q;
  wire       scl_fall   = ~scl_s & scl_p_q;
  wire       start_det  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire       stop_det   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire       mode_bus   = ~mode_strap_q[3];
  wire       pol_high   = addr_strap_q[3];
  wire [2:0] addr_idx   = addr_strap_q[3] ? ~addr_strap_q[2:0] : addr_strap_q[2:0];
  wire [6:0] my_addr    = ADDR_TABLE[addr_idx];
  wire       tdis       = ctrl_q[CTRL_TDIS_BIT];
  wire       sleeping   = ctrl_q[CTRL_SLEEP_BIT];
  wire       bus_go     = start_det & ready_q & mode_bus;
  wire       tmo_hit    = ~tdis & (low_cnt_q >= 24'(TIMEOUT_CYCLES));
  wire       idle_hit   = ~tdis & ~sleeping & (hi_cnt_q >= 24'(IDLE_CYCLES));
  wire       abort      = (st_q != S_IDLE) & (tmo_hit | idle_hit | stop_det);
  wire       byte_end   = (st_q == S_RX) & scl_fall & (cnt_q == 4'h8);
  wire       addr_hit   = (sh_q[7:1] == my_addr);
  wire       data_wr    = byte_end & (kind_q == K_DATA) & ~sleeping;
  wire       wake_read  = byte_end & (kind_q == K_ADDR) & addr_hit & sh_q[0];
  wire       load_tx    = scl_fall & (((st_q == S_ACK) & rw_q) | (st_q == S_HACK));
  wire [7:0] strap_view = {3'h0, pol_high, mode_bus, mode_strap_q[2:0]};
  wire [7:0] rd_data    = (ptr_q == REG_CTRL)          ? ctrl_q :
                          (ptr_q == REG_STRAP)         ? strap_view :
                          (ptr_q == REG_PRODUCT_IDENTIFIER)    ? PRODUCT_IDENTIFIER_VAL :
                          (ptr_q == REG_MAKER_ID)      ? MAKER_ID_VAL :
                          (ptr_q == REG_PART_REVISION) ? PART_REVISION_VAL : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q   <= 11'h7FF;
      sy2_q   <= 11'h7FF;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sy1_q   <= {port_power_enable, addr_strap_pin, mode_limit_strap_pin, link.sda, link.scl};
      sy2_q   <= sy1_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Straps are caught once, when the power-up silence ends.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_q    <= 24'h000000;
      ready_q      <= 1'b0;
      mode_strap_q <= 4'hF;
      addr_strap_q <= 4'h0;
    end else if (!ready_q) begin
      pwr_cnt_q <= pwr_cnt_q + 24'h000001;
      if (pwr_cnt_q == 24'(PWRUP_CYCLES - 1)) begin
        ready_q      <= 1'b1;
        mode_strap_q <= mode_s;
        addr_strap_q <= addr_s;
      end
    end
  end

  // Decoded strap outputs are registered so every output leaves a flip-flop.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_on_q    <= 1'b0;
      mode_bus_q <= 1'b0;
      addr_q     <= ADDR_TABLE[0];
    end else begin
      sw_on_q    <= ready_q & (pen_s == pol_high);
      mode_bus_q <= mode_bus;
      addr_q     <= my_addr;
    end
  end

  // Counters saturate so a held line keeps its reset pending.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= 24'h000000;
      hi_cnt_q  <= 24'h000000;
    end else begin
      if (scl_s) begin
        low_cnt_q <= 24'h000000;
      end else if (low_cnt_q != 24'hFFFFFF) begin
        low_cnt_q <= low_cnt_q + 24'h000001;
      end
      if (!(scl_s & sda_s)) begin
        hi_cnt_q <= 24'h000000;
      end else if (hi_cnt_q != 24'hFFFFFF) begin
        hi_cnt_q <= hi_cnt_q + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wake_read) begin
      ctrl_q[CTRL_SLEEP_BIT] <= 1'b0;
    end else if (data_wr && ptr_q == REG_CTRL) begin
      ctrl_q <= sh_q & CTRL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= S_IDLE;
      kind_q   <= K_ADDR;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      ptr_q    <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (bus_go) begin
      st_q     <= S_RX;
      kind_q   <= K_ADDR;
      cnt_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (abort) begin
      st_q     <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else if (load_tx) begin
      st_q     <= S_TX;
      tx_q     <= {rd_data[6:0], 1'b0};
      sda_oe_q <= ~rd_data[7];
      cnt_q    <= 4'h1;
    end else begin
      case (st_q)
        S_RX: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            if (kind_q != K_ADDR || addr_hit) begin
              st_q     <= S_ACK;
              sda_oe_q <= 1'b1;
            end else begin
              st_q <= S_IDLE;
            end
            case (kind_q)
              K_ADDR:  rw_q  <= sh_q[0];
              K_REG:   ptr_q <= sh_q;
              default: ptr_q <= ptr_q + 8'h01;
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            st_q     <= S_RX;
            sda_oe_q <= 1'b0;
            cnt_q    <= 4'h0;
            kind_q   <= (kind_q == K_ADDR) ? K_REG : K_DATA;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              st_q     <= S_HACK;
              sda_oe_q <= 1'b0;
              ptr_q    <= ptr_q + 8'h01;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
              cnt_q    <= cnt_q + 4'h1;
            end
          end
        end
        S_HACK: begin
          if (scl_rise && sda_s) begin
            st_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // The clock line is only ever sensed here, never driven.
  assign link.sda_d_oe          = sda_oe_q;
  assign link.sda_d_out         = 1'b0;
  assign bus_ready              = ready_q;
  assign smbus_mode             = mode_bus_q;
  assign hardware_current_limit = mode_strap_q[2:0];
  assign client_address         = addr_q;
  assign enable_active_high     = pol_high;
  assign port_switch_on         = sw_on_q;
  assign timeout_disable_bit    = ctrl_q[CTRL_TDIS_BIT];
  assign asleep                 = ctrl_q[CTRL_SLEEP_BIT];
endmodule : scp_client_dev
`default_nettype wire

// *** verilog/scp_host_ctl.sv ***
`timescale 1ns/100ps
`default_nettype none
module scp_host_ctl #(
  parameter int WAKE_CYCLES = scp_pkg::WAKE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  scp_link_if.host         link
);
  import scp_pkg::*;

  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;
  logic [6:0]      target_q;
  logic [7:0]      regptr_q;
  logic [7:0]      wdata_q;
  logic [7:0]      rdata_q;
  logic [1:0]      op_q;
  logic            wake_q;
  logic            nack_q;
  logic [23:0]     wcnt_q;
  logic [1:0]      sda_sy_q;
  scp_host_state_t st_q;
  logic [7:0]      qcnt_q;
  logic [1:0]      ph_q;
  logic [3:0]      bit_q;
  logic [2:0]      step_q;
  logic [7:0]      sh_q;
  logic            scl_oe_q;
  logic            sda_oe_q;

  wire       sda_s    = sda_sy_q[1];
  wire       busy     = (st_q != H_IDLE) | (wcnt_q != 24'h000000);
  wire       setup    = psel & ~penable & ~pready_q;
  wire       wr_done  = psel & penable & pready_q & pwrite;
  wire       go       = wr_done & (paddr == HREG_CMD) & ~busy;
  wire       tick     = (qcnt_q == HOST_QTR_CYC - 8'h01);
  wire       rx       = (step_q == 3'h4);
  wire       byte_fin = (st_q == H_BYTE) & tick & (ph_q == 2'h3) & (bit_q == 4'h8);
  wire       last     = nack_q | rx | (step_q == 3'h2) | ((step_q == 3'h1) & (op_q == OP_SEND));
  wire       restart  = (step_q == 3'h1) & (op_q == OP_READ);
  wire [2:0] nxt_step = restart ? 3'h3 : step_q + 3'h1;
  wire [7:0] tx_byte  = (nxt_step == 3'h1) ? regptr_q :
                        (nxt_step == 3'h2) ? wdata_q : {target_q, 1'b1};
  wire       mapped   = (paddr == HREG_CMD) | (paddr == HREG_TARGET) | (paddr == HREG_REGPTR) |
                        (paddr == HREG_WDATA) | (paddr == HREG_RDATA) | (paddr == HREG_STATUS);
  wire [7:0] rd_mux   = (paddr == HREG_TARGET) ? {1'b0, target_q} :
                        (paddr == HREG_REGPTR) ? regptr_q :
                        (paddr == HREG_WDATA)  ? wdata_q :
                        (paddr == HREG_RDATA)  ? rdata_q :
                        (paddr == HREG_STATUS) ? {5'h00, wcnt_q != 24'h000000, nack_q, busy} :
                        8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= setup ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= 7'h00;
      regptr_q <= 8'h00;
      wdata_q  <= 8'h00;
    end else if (wr_done && !busy) begin
      if (paddr == HREG_TARGET) target_q <= pwdata[6:0];
      if (paddr == HREG_REGPTR) regptr_q <= pwdata[7:0];
      if (paddr == HREG_WDATA)  wdata_q  <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sy_q <= 2'h3;
    end else begin
      sda_sy_q <= {sda_sy_q[0], link.sda};
    end
  end

  // Bus sequencer: each bit is four quarters of low, rise, sample, fall.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= H_IDLE;
      qcnt_q   <= 8'h00;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      step_q   <= 3'h0;
      sh_q     <= 8'h00;
      op_q     <= OP_WRITE;
      wake_q   <= 1'b0;
      nack_q   <= 1'b0;
      rdata_q  <= 8'h00;
      wcnt_q   <= 24'h000000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (go) begin
      st_q   <= H_START;
      op_q   <= pwdata[1:0];
      wake_q <= pwdata[CMD_WAKE_BIT];
      nack_q <= 1'b0;
      step_q <= (pwdata[1:0] == OP_RECEIVE) ? 3'h3 : 3'h0;
      qcnt_q <= 8'h00;
      ph_q   <= 2'h0;
    end else if (st_q == H_IDLE) begin
      if (wcnt_q != 24'h000000) wcnt_q <= wcnt_q - 24'h000001;
    end else begin
      qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          H_START: begin
            case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              default: begin
                scl_oe_q <= 1'b1;
                st_q     <= H_BYTE;
                bit_q    <= 4'h0;
                sh_q     <= (step_q == 3'h0) ? {target_q, 1'b0} : {target_q, 1'b1};
              end
            endcase
          end
          H_BYTE: begin
            case (ph_q)
              2'h0: sda_oe_q <= (bit_q != 4'h8) & ~rx & ~sh_q[7];
              2'h1: scl_oe_q <= 1'b0;
              2'h2: begin
                if (bit_q != 4'h8) sh_q <= {sh_q[6:0], sda_s};
                else if (!rx && sda_s) nack_q <= 1'b1;
              end
              default: begin
                scl_oe_q <= 1'b1;
                bit_q    <= bit_q + 4'h1;
                if (byte_fin) begin
                  if (rx) rdata_q <= sh_q;
                  if (last) st_q <= H_STOP;
                  else if (restart) st_q <= H_START;
                  bit_q  <= 4'h0;
                  step_q <= nxt_step;
                  sh_q   <= tx_byte;
                end
              end
            endcase
          end
          H_STOP: begin
            case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              default: begin
                st_q <= H_IDLE;
                if (wake_q && op_q[1]) wcnt_q <= 24'(WAKE_CYCLES);
              end
            endcase
          end
          default: st_q <= H_IDLE;
        endcase
      end
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign link.scl_oe    = scl_oe_q;
  assign link.scl_out   = 1'b0;
  assign link.sda_h_oe  = sda_oe_q;
  assign link.sda_h_out = 1'b0;
endmodule : scp_host_ctl
`default_nettype wire

// *** bench/scp_link_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module scp_link_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_oe,
  input wire logic scl_out,
  input wire logic sda_h_oe,
  input wire logic sda_h_out,
  input wire logic sda_d_oe,
  input wire logic sda_d_out,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_scl_host_only; !scl |-> scl_oe; endproperty
  a_scl_host_only: assert property (p_scl_host_only) else $error("clock low without host");
  property p_open_drain; !sda_d_out && !scl_out && !sda_h_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_dev_drive; $rose(sda_d_oe) |-> !scl && $past(!scl, 2); endproperty
  a_dev_drive: assert property (p_dev_drive) else $error("device drives near clock edge");
  property p_dev_release; $fell(sda_d_oe) |-> !scl; endproperty
  a_dev_release: assert property (p_dev_release) else $error("device released while clock high");
  property p_dev_stable; scl && $past(scl) |-> $stable(sda_d_oe); endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved while clock high");
  property p_start_host; scl && $past(scl) && $fell(sda) |-> $rose(sda_h_oe); endproperty
  a_start_host: assert property (p_start_host) else $error("start not made by host");
  property p_stop_host; scl && $past(scl) && $rose(sda) |-> $fell(sda_h_oe); endproperty
  a_stop_host: assert property (p_stop_host) else $error("stop not made by host");
  property p_reset_rel; $rose(rst_n) |-> !sda_d_oe && !scl_oe && !sda_h_oe; endproperty
  a_reset_rel: assert property (p_reset_rel) else $error("lines held after reset");
  property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
endmodule : scp_link_sva
`default_nettype wire

// *** bench/smbus_client_port_with_strap_decode_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module smbus_client_port_with_strap_decode_tb;
  import scp_pkg::*;
  localparam int PWRUP = 200;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [3:0]  mstrap = 4'h0;
  logic [3:0]  astrap = 4'h0;
  logic        ppe = 1'b0;
  logic        bus_ready, smbus_mode, act_hi, sw_on, tdis, asleep;
  logic [2:0]  lim;
  logic [6:0]  caddr;
  int          err_count = 0;
  int          comparisons = 0;
  always #2 mclk = ~mclk;
  scp_link_if u_scp_link_if ();
  scp_host_ctl #(.WAKE_CYCLES(50)) u_scp_host_ctl (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(u_scp_link_if));
  scp_client_dev #(.PWRUP_CYCLES(PWRUP), .TIMEOUT_CYCLES(400), .IDLE_CYCLES(300)) u_scp_client_dev (
    .mclk(mclk), .rst_n(rst_n), .link(u_scp_link_if), .mode_limit_strap_pin(mstrap),
    .addr_strap_pin(astrap), .port_power_enable(ppe), .bus_ready(bus_ready),
    .smbus_mode(smbus_mode), .hardware_current_limit(lim), .client_address(caddr),
    .enable_active_high(act_hi), .port_switch_on(sw_on), .timeout_disable_bit(tdis),
    .asleep(asleep));
  scp_link_sva u_scp_link_sva (.mclk(mclk), .rst_n(rst_n), .scl_oe(u_scp_link_if.scl_oe),
    .scl_out(u_scp_link_if.scl_out), .sda_h_oe(u_scp_link_if.sda_h_oe),
    .sda_h_out(u_scp_link_if.sda_h_out), .sda_d_oe(u_scp_link_if.sda_d_oe),
    .sda_d_out(u_scp_link_if.sda_d_out), .scl(u_scp_link_if.scl), .sda(u_scp_link_if.sda));

  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // Look at the answer mid-cycle, where it is settled, then complete on the next edge.
    @(negedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 50) err_count++;
    q = prdata;
    last_err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Runs one bus transfer; st holds {wake wait seen in any poll, nack and busy of the last poll}.
  task automatic op(input logic [2:0] cmd, input logic [6:0] tgt, input logic [7:0] rp,
                    input logic [7:0] wd, output logic [7:0] rd, output logic [2:0] st);
    logic [31:0] q;
    logic        wk;
    int          n;
    apb(1'b1, HREG_TARGET, {25'h0, tgt}, q);
    apb(1'b1, HREG_REGPTR, {24'h0, rp}, q);
    apb(1'b1, HREG_WDATA, {24'h0, wd}, q);
    apb(1'b1, HREG_CMD, {29'h0, cmd}, q);
    wk = 1'b0;
    n = 0;
    do begin
      apb(1'b0, HREG_STATUS, 32'h0, q);
      wk = wk | q[2];
      n++;
    end while (q[0] !== 1'b0 && n < 4000);
    if (n >= 4000) err_count++;
    st = {wk, q[1:0]};
    apb(1'b0, HREG_RDATA, 32'h0, q);
    rd = q[7:0];
  endtask : op

  function automatic logic [6:0] exp_addr(input logic [3:0] s);
    logic [3:0] k;
    k = s[3] ? 4'hF - s : s;
    return (k < 4'h4) ? 7'h57 - {3'h0, k} : 7'h2C + {3'h0, k};
  endfunction : exp_addr

  initial begin
    #200000;
    err_count++;
    final_report();
  end

  initial begin
    logic [7:0]  rd;
    logic [2:0]  st;
    logic [31:0] q;
    logic [6:0]  a;
    logic [7:0]  v;
    logic [7:0]  ids [3];
    ids = '{PRODUCT_IDENTIFIER_VAL, MAKER_ID_VAL, PART_REVISION_VAL};
    void'($urandom(47814));
    repeat (6) @(posedge mclk);
    mstrap <= 4'($urandom_range(7));
    astrap <= 4'($urandom());
    ppe <= 1'($urandom());
    rst_n <= 1'b1;
    @(posedge mclk);
    a = exp_addr(astrap);
    op({1'b0, OP_RECEIVE}, a, 8'h00, 8'h00, rd, st);
    chk("early nack", st[1], 1'b1);
    repeat (PWRUP) @(posedge mclk);
    chk("bus_ready", bus_ready, 1'b1);
    chk("smbus_mode", smbus_mode, 1'b1);
    chk("limit", lim, mstrap[2:0]);
    chk("address", caddr, a);
    chk("polarity", act_hi, astrap[3]);
    chk("switch", sw_on, ppe == astrap[3]);
    apb(1'b0, 8'h18, 32'h0, q);
    chk("unmapped err", last_err, 1'b1);
    $display("test straps done");
    for (int i = 0; i < 3; i++) begin
      op({1'b0, OP_READ}, a, REG_PRODUCT_IDENTIFIER + 8'(i), 8'h00, rd, st);
      chk("id ack", st[1], 1'b0);
      chk("id value", rd, ids[i]);
    end
    op({1'b0, OP_READ}, a ^ 7'($urandom_range(1, 127)), REG_MAKER_ID, 8'h00, rd, st);
    chk("foreign nack", st[1], 1'b1);
    v = 8'($urandom());
    op({1'b0, OP_WRITE}, a, REG_PRODUCT_IDENTIFIER, v, rd, st);
    chk("id write ack", st[1], 1'b0);
    op({1'b0, OP_READ}, a, REG_PRODUCT_IDENTIFIER, 8'h00, rd, st);
    chk("id kept", rd, PRODUCT_IDENTIFIER_VAL);
    $display("test ids done");
    chk("tdis reset", tdis, 1'b1);
    op({1'b0, OP_WRITE}, a, REG_CTRL, 8'h00, rd, st);
    chk("tdis cleared", tdis, 1'b0);
    op({1'b0, OP_SEND}, a, REG_MAKER_ID, 8'h00, rd, st);
    op({1'b0, OP_RECEIVE}, a, 8'h00, 8'h00, rd, st);
    chk("pointer set", rd, MAKER_ID_VAL);
    op({1'b0, OP_RECEIVE}, a, 8'h00, 8'h00, rd, st);
    chk("pointer step", rd, PART_REVISION_VAL);
    op({1'b0, OP_RECEIVE}, a, 8'h00, 8'h00, rd, st);
    chk("pointer wrap", rd, 8'h00);
    $display("test pointer done");
    op({1'b0, OP_WRITE}, a, REG_CTRL, 8'h02, rd, st);
    chk("asleep", asleep, 1'b1);
    op({1'b0, OP_WRITE}, a, REG_CTRL, 8'h01, rd, st);
    chk("sleep write dropped", tdis, 1'b0);
    op({1'b1, OP_READ}, a, REG_PRODUCT_IDENTIFIER, 8'h00, rd, st);
    chk("woken", asleep, 1'b0);
    chk("wake wait", st[2], 1'b1);
    $display("test sleep done");
    ppe <= ~ppe;
    repeat (4) @(posedge mclk);
    chk("switch toggled", sw_on, ppe == astrap[3]);
    $display("test enable done");
    // Second power-up with a stand-alone strap: the bus must stay silent.
    rst_n <= 1'b0;
    mstrap <= 4'h8 + 4'($urandom_range(7));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (PWRUP + 4) @(posedge mclk);
    chk("standalone mode", smbus_mode, 1'b0);
    chk("standalone limit", lim, mstrap[2:0]);
    chk("standalone address", caddr, a);
    op({1'b0, OP_READ}, a, REG_PRODUCT_IDENTIFIER, 8'h00, rd, st);
    chk("standalone nack", st[1], 1'b1);
    $display("test standalone done");
    final_report();
  end
endmodule : smbus_client_port_with_strap_decode_tb
`default_nettype wire
